/* logic/alu_format_decoder_params.svh */
// constants for the compact alu format decoder: prefixes, codes, field positions
// assumes nothing; included by the package and by the decoder module
`ifndef ALU_FORMAT_DECODER_PARAMS_SVH
`define ALU_FORMAT_DECODER_PARAMS_SVH

// datapath width
`define DATA_WIDTH 32
// format prefixes
`define PFX_SHIFT 3'h0
`define PFX_IMM8 3'h1
`define SEL_ADDSUB 2'h3
`define PFX_HIREG 6'h11
`define PFX_LOADADDR 4'hA
`define PFX_SPOFS 8'hB0
// operation_select codes
`define SHOP_LEFT 2'h0
`define SHOP_RIGHT 2'h1
`define SHOP_ARITH 2'h2
`define IMMOP_MOVE 2'h0
`define IMMOP_COMPARE 2'h1
`define IMMOP_ADD 2'h2
`define IMMOP_SUB 2'h3
`define HIOP_ADD 2'h0
`define HIOP_MOVE 2'h2
// format numbers reported to the datapath
`define FORMAT_OTHER 5'h00
`define FORMAT_SHIFT 5'h01
`define FORMAT_ADDSUB 5'h02
`define FORMAT_IMM8 5'h03
`define FORMAT_HIREG 5'h05
`define FORMAT_LOADADDR 5'h0C
`define FORMAT_SPOFS 5'h0D
// field positions
`define POS_DEST_LO 0
`define POS_SRC_LO 3
`define POS_SECOND_LO 6
`define POS_IMMSEL 10
`define POS_ADDSUB_OP 9
`define POS_SHAMT_LO 6
`define POS_IMM8_DEST_LO 8
// decode latency in cycles, equal for every accepted halfword
`define DECODE_LATENCY 1

`endif

/* logic/alu_format_decoder_pkg.sv */
// types for the compact alu format decoder
// assumes the params header is on the include path
`include "alu_format_decoder_params.svh"

package alu_format_decoder_pkg;

    // datapath operation driven to execute
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SHL = 3'h1,
        OP_SHR = 3'h3,
        OP_SAR = 3'h2,
        OP_ADD = 3'h6,
        OP_SUB = 3'h7,
        OP_MOV = 3'h5
    } alu_op_t;

    // whole decoder state, registered once per accepted halfword
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [4:0] format;
        logic [2:0] dest;
        logic [2:0] src_a;
        logic [2:0] src_b;
        logic b_is_imm;
        logic [`DATA_WIDTH-1:0] imm;
        logic write_dest;
        logic flags_update;
        logic flags_kept;
    } decode_state_t;

endpackage

/* logic/compact_isa_alu_format_decoder.sv */
// decoder for the compact shift, add/subtract and 8-bit immediate formats
// assumes fetch offers halfwords with valid/ready and execute accepts with ready
//
// Contract
// - opcode 00: shift left by five-bit amount
// - opcode 01: logical right shift by amount
// - opcode 10: arithmetic right shift by amount
// - these three formats always update condition flags
// - add second register to source register
// - add zero-extended three-bit immediate to source
// - subtract second register from source register
// - subtract three-bit immediate from source register
// - byte immediate: load zero-extended byte
// - byte immediate: compare only, no write
// - byte immediate: add into same register
// - byte immediate: subtract from same register
// - same latency and operation as wide form
// - add in formats 5/12/13 keeps flags
// - move in format 5 keeps flags
`timescale 1ns/1ps
`include "alu_format_decoder_params.svh"

module compact_isa_alu_format_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // halfword from fetch
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_ready,
    // decoded controls to execute
    input wire logic exec_ready,
    output logic dec_valid,
    output alu_format_decoder_pkg::alu_op_t dec_op,
    output logic [4:0] dec_format,
    output logic [2:0] dec_dest,
    output logic [2:0] dec_src_a,
    output logic [2:0] dec_src_b,
    output logic dec_b_is_imm,
    output logic [`DATA_WIDTH-1:0] dec_imm,
    output logic dec_write_dest,
    output logic dec_flags_update,
    output logic dec_flags_kept
);

    ////////////////////////////////////////////////////////////////////////////
    // decode function

    // pure decode of one halfword; no state, so every format costs the same
    function automatic alu_format_decoder_pkg::decode_state_t decode(
        input logic [15:0] h
    );
        alu_format_decoder_pkg::decode_state_t d;
        d = '0;
        d.valid = 1'b1;
        d.format = `FORMAT_OTHER;
        d.op = alu_format_decoder_pkg::OP_NONE;
        if (h[15:13] == `PFX_SHIFT && h[12:11] == `SEL_ADDSUB) begin
            // opcode 11 of the shift group is the add/subtract group
            d.format = `FORMAT_ADDSUB;
            d.dest = h[`POS_DEST_LO +: 3];
            d.src_a = h[`POS_SRC_LO +: 3];
            d.src_b = h[`POS_SECOND_LO +: 3];
            d.b_is_imm = h[`POS_IMMSEL];
            // immediate is the same field as the second register, zero extended
            d.imm = {{(`DATA_WIDTH-3){1'b0}}, h[`POS_SECOND_LO +: 3]};
            d.write_dest = 1'b1;
            d.flags_update = 1'b1;
            if (h[`POS_ADDSUB_OP]) begin
                d.op = alu_format_decoder_pkg::OP_SUB;
            end else begin
                d.op = alu_format_decoder_pkg::OP_ADD;
            end
        end else if (h[15:13] == `PFX_SHIFT) begin
            // shift by immediate, amount carried as immediate operand
            d.format = `FORMAT_SHIFT;
            d.dest = h[`POS_DEST_LO +: 3];
            d.src_a = h[`POS_SRC_LO +: 3];
            d.b_is_imm = 1'b1;
            d.imm = {{(`DATA_WIDTH-5){1'b0}}, h[`POS_SHAMT_LO +: 5]};
            d.write_dest = 1'b1;
            d.flags_update = 1'b1;
            unique case (h[12:11])
                `SHOP_LEFT: d.op = alu_format_decoder_pkg::OP_SHL;
                `SHOP_RIGHT: d.op = alu_format_decoder_pkg::OP_SHR;
                `SHOP_ARITH: d.op = alu_format_decoder_pkg::OP_SAR;
                // 11 never reaches here, taken by the branch above
                default: d.op = alu_format_decoder_pkg::OP_NONE;
            endcase
        end else if (h[15:13] == `PFX_IMM8) begin
            // byte immediate against one register, which is both source and dest
            d.format = `FORMAT_IMM8;
            d.dest = h[`POS_IMM8_DEST_LO +: 3];
            d.src_a = h[`POS_IMM8_DEST_LO +: 3];
            d.b_is_imm = 1'b1;
            d.imm = {{(`DATA_WIDTH-8){1'b0}}, h[7:0]};
            d.flags_update = 1'b1;
            unique case (h[12:11])
                `IMMOP_MOVE: begin
                    d.op = alu_format_decoder_pkg::OP_MOV;
                    d.write_dest = 1'b1;
                end
                `IMMOP_COMPARE: begin
                    // compare only: result discarded, flags updated from it
                    d.op = alu_format_decoder_pkg::OP_SUB;
                    d.write_dest = 1'b0;
                end
                `IMMOP_ADD: begin
                    d.op = alu_format_decoder_pkg::OP_ADD;
                    d.write_dest = 1'b1;
                end
                `IMMOP_SUB: begin
                    d.op = alu_format_decoder_pkg::OP_SUB;
                    d.write_dest = 1'b1;
                end
            endcase
        end else if (h[15:10] == `PFX_HIREG &&
                     (h[9:8] == `HIOP_ADD || h[9:8] == `HIOP_MOVE)) begin
            // high-register add or move: executed elsewhere, flags untouched
            d.format = `FORMAT_HIREG;
            d.flags_kept = 1'b1;
        end else if (h[15:8] == `PFX_SPOFS) begin
            // stack pointer offset add, prefix does not overlap the load address prefix
            d.format = `FORMAT_SPOFS;
            d.flags_kept = 1'b1;
        end else if (h[15:12] == `PFX_LOADADDR) begin
            // load address add
            d.format = `FORMAT_LOADADDR;
            d.flags_kept = 1'b1;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state and handshake

    // registered decode result
    alu_format_decoder_pkg::decode_state_t state;
    // value for the next edge
    alu_format_decoder_pkg::decode_state_t next_state;
    // halfword taken this cycle
    logic accept;

    // take a new halfword whenever the output slot is free or being drained
    assign instr_ready = !state.valid || exec_ready;
    assign accept = instr_valid && instr_ready;

    // next state: load on accept, clear valid on drain, else hold
    always_comb begin
        next_state = state;
        if (accept) begin
            // one fixed stage for every format keeps wide-form timing
            next_state = decode(instr);
        end else if (exec_ready) begin
            next_state.valid = 1'b0;
        end
    end

    // the single register of the block
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, straight from the register

    assign dec_valid = state.valid;
    assign dec_op = state.op;
    assign dec_format = state.format;
    assign dec_dest = state.dest;
    assign dec_src_a = state.src_a;
    assign dec_src_b = state.src_b;
    assign dec_b_is_imm = state.b_is_imm;
    assign dec_imm = state.imm;
    assign dec_write_dest = state.write_dest;
    assign dec_flags_update = state.flags_update;
    assign dec_flags_kept = state.flags_kept;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    shift_left_a: assert property (accept && instr[15:11] == 5'h00 |=>
        dec_op == alu_format_decoder_pkg::OP_SHL && dec_imm[4:0] == $past(instr[10:6])
        && dec_imm[31:5] == 27'h0 && dec_write_dest)
        else $error("shift left decode wrong");
    shift_right_a: assert property (accept && instr[15:11] == 5'h01 |=>
        dec_op == alu_format_decoder_pkg::OP_SHR && dec_dest == $past(instr[2:0]))
        else $error("logical right decode wrong");
    shift_arith_a: assert property (accept && instr[15:11] == 5'h02 |=>
        dec_op == alu_format_decoder_pkg::OP_SAR && dec_src_a == $past(instr[5:3]))
        else $error("arithmetic right decode wrong");
    flags_set_a: assert property (accept && instr[15:14] == 2'h0 |=>
        dec_valid && dec_flags_update && !dec_flags_kept)
        else $error("flags not updated");
    add_reg_a: assert property (accept && instr[15:9] == 7'h0C |=>
        dec_op == alu_format_decoder_pkg::OP_ADD && !dec_b_is_imm
        && dec_src_b == $past(instr[8:6]))
        else $error("register add decode wrong");
    add_small_a: assert property (accept && instr[15:9] == 7'h0E |=>
        dec_op == alu_format_decoder_pkg::OP_ADD && dec_b_is_imm
        && dec_imm == {29'h0, $past(instr[8:6])})
        else $error("small immediate add wrong");
    sub_any_a: assert property (accept && instr[15:11] == 5'h03 && instr[9] |=>
        dec_op == alu_format_decoder_pkg::OP_SUB && dec_format == 5'h02
        && dec_b_is_imm == $past(instr[10]))
        else $error("subtract decode wrong");
    byte_move_a: assert property (accept && instr[15:11] == 5'h04 |=>
        dec_op == alu_format_decoder_pkg::OP_MOV && dec_imm == {24'h000000, $past(instr[7:0])})
        else $error("byte move decode wrong");
    compare_nowrite_a: assert property (accept && instr[15:11] == 5'h05 |=>
        dec_op == alu_format_decoder_pkg::OP_SUB && !dec_write_dest && dec_flags_update)
        else $error("compare writes register");
    byte_addsub_a: assert property (accept && instr[15:12] == 4'h3 |=>
        dec_write_dest && dec_dest == dec_src_a && dec_dest == $past(instr[10:8]))
        else $error("byte add or subtract target wrong");
    fixed_latency_a: assert property (accept |=> dec_valid ##0
        (dec_format != 5'h00 || dec_op == alu_format_decoder_pkg::OP_NONE))
        else $error("decode not ready one cycle later");
    flags_kept_a: assert property (accept && instr[15:12] == 4'hA |=>
        dec_flags_kept && !dec_flags_update)
        else $error("load address add touched flags");
    hi_move_a: assert property (accept && instr[15:8] == 8'h46 |=>
        dec_flags_kept && !dec_flags_update && dec_format == 5'h05)
        else $error("high move touched flags");
    no_shift11_a: assert property (accept && instr[15:11] == 5'h03 |=>
        dec_op != alu_format_decoder_pkg::OP_SHL && dec_op != alu_format_decoder_pkg::OP_SHR
        && dec_op != alu_format_decoder_pkg::OP_SAR)
        else $error("opcode 11 decoded as shift");
    hold_stall_a: assert property (dec_valid && !exec_ready |=> dec_valid && $stable(dec_op)
        && $stable(dec_imm))
        else $error("output changed while stalled");

endmodule // compact_isa_alu_format_decoder

/* verification/compact_isa_alu_format_decoder_test.sv */
// self-checking bench for the compact alu format decoder
// assumes execute_sink on the decoded side; fetch is driven here
`timescale 1ns/1ps
`include "alu_format_decoder_params.svh"

module compact_isa_alu_format_decoder_test;
    // stimulus, all valued at time zero
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic hold_off = 1'b0;
    // decoder outputs, plus exec_ready from the sink
    logic instr_ready;
    logic exec_ready;
    logic dec_valid;
    alu_format_decoder_pkg::alu_op_t dec_op;
    logic [4:0] dec_format;
    logic [2:0] dec_dest;
    logic [2:0] dec_src_a;
    logic [2:0] dec_src_b;
    logic dec_b_is_imm;
    logic [`DATA_WIDTH-1:0] dec_imm;
    logic dec_write_dest;
    logic dec_flags_update;
    logic dec_flags_kept;
    // bookkeeping
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    compact_isa_alu_format_decoder u_dut (.clk(clk), .reset(reset),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
        .exec_ready(exec_ready), .dec_valid(dec_valid), .dec_op(dec_op),
        .dec_format(dec_format), .dec_dest(dec_dest), .dec_src_a(dec_src_a),
        .dec_src_b(dec_src_b), .dec_b_is_imm(dec_b_is_imm), .dec_imm(dec_imm),
        .dec_write_dest(dec_write_dest), .dec_flags_update(dec_flags_update),
        .dec_flags_kept(dec_flags_kept));
    execute_sink u_sink (.clk(clk), .reset(reset), .hold_off(hold_off),
        .exec_ready(exec_ready));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // hang guard: the whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic compare(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // packed view of the decode: op, format, dest, src_a, write/update/kept, imm
    function automatic logic [63:0] ex(input logic [2:0] op, input logic [4:0] f,
        input logic [2:0] d, input logic [2:0] s, input logic [2:0] wuk,
        input logic [31:0] imm);
        return {15'h0, op, f, d, s, wuk, imm};
    endfunction

    function automatic logic [63:0] word();
        return {15'h0, dec_op, dec_format, dec_dest, dec_src_a, dec_write_dest,
            dec_flags_update, dec_flags_kept, dec_imm};
    endfunction

    // offer one halfword, hold it until taken, judge the decode a cycle later
    task automatic issue(input logic [15:0] h, input logic [63:0] exp,
        input logic [63:0] m = 64'hFFFF_FFFF_FFFF_FFFF);
        int n;
        n = 0;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= h;
        @(negedge clk);
        while (instr_ready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        // a fetch side that never sees ready counts as a failure, not a silent pass
        compare({63'h0, instr_ready}, 64'h1);
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
        compare({63'h0, dec_valid}, 64'h1);
        compare(word() & m, exp & m);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // every shift code at the largest amount
    task automatic shift_cases();
        logic [2:0] ops [3] = '{3'h1, 3'h3, 3'h2};
        for (int k = 0; k < 3; k++) begin
            issue({3'h0, k[1:0], 5'h1F, 3'h5, 3'h2}, ex(ops[k], 5'h01, 3'h2, 3'h5, 3'h6,
                32'h1F));
        end
        issue(16'h1C8A, ex(3'h6, 5'h02, 3'h2, 3'h1, 3'h6, 32'h2));
    endtask

    // register and immediate forms of add and subtract
    task automatic addsub_cases();
        for (int i = 0; i < 2; i++) begin
            for (int o = 0; o < 2; o++) begin
                issue({5'h03, i[0], o[0], 3'h6, 3'h3, 3'h4},
                    ex(o ? 3'h7 : 3'h6, 5'h02, 3'h4, 3'h3, 3'h6, 32'h6),
                    i ? 64'hFFFF_FFFF_FFFF_FFFF : 64'hFFFF_FFFF_0000_0000);
                compare({60'h0, dec_b_is_imm, i ? 3'h6 : dec_src_b},
                    {60'h0, i[0], 3'h6});
            end
        end
    endtask

    // byte immediate: compare must not write back
    task automatic imm8_cases();
        logic [2:0] ops [4] = '{3'h5, 3'h7, 3'h6, 3'h7};
        for (int o = 0; o < 4; o++) begin
            issue({3'h1, o[1:0], 3'h5, 8'hFF}, ex(ops[o], 5'h03, 3'h5, 3'h5,
                (o == 1) ? 3'h2 : 3'h6, 32'hFF));
        end
    endtask

    // adds and moves that leave flags alone; hi-register compare is not one
    task automatic kept_cases();
        logic [15:0] hw [4] = '{16'h4440, 16'h4640, 16'hAFFF, 16'hB0FF};
        logic [4:0] fm [4] = '{5'h05, 5'h05, 5'h0C, 5'h0D};
        for (int k = 0; k < 4; k++) begin
            issue(hw[k], ex(3'h0, fm[k], 3'h0, 3'h0, 3'h1, 32'h0));
        end
        issue(16'h4540, ex(3'h0, 5'h00, 3'h0, 3'h0, 3'h0, 32'h0));
    endtask

    // execute stalls: next halfword refused, held decode stays put
    task automatic stall_case();
        @(posedge clk);
        hold_off <= 1'b1;
        issue(16'h2210, ex(3'h5, 5'h03, 3'h2, 3'h2, 3'h6, 32'h10));
        fork
            issue(16'h3B01, ex(3'h7, 5'h03, 3'h3, 3'h3, 3'h6, 32'h1));
            begin
                repeat (3) begin
                    @(negedge clk);
                    compare({60'h0, instr_ready, dec_dest}, 64'h2);
                end
                @(posedge clk);
                hold_off <= 1'b0;
            end
        join
    endtask

    // reset while a decode is held: slot empties, fetch side ready, then recovers
    task automatic reset_case();
        @(posedge clk);
        hold_off <= 1'b1;
        issue(16'h2310, ex(3'h5, 5'h03, 3'h3, 3'h3, 3'h6, 32'h10));
        @(posedge clk);
        reset <= 1'b1;
        @(negedge clk);
        compare({62'h0, dec_valid, instr_ready}, 64'h1);
        @(posedge clk);
        reset <= 1'b0;
        hold_off <= 1'b0;
        issue(16'h1C8A, ex(3'h6, 5'h02, 3'h2, 3'h1, 3'h6, 32'h2));
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        shift_cases();
        addsub_cases();
        imm8_cases();
        kept_cases();
        stall_case();
        reset_case();
        give_verdict();
    end
endmodule // compact_isa_alu_format_decoder_test

/* verification/execute_sink.sv */
// execute-side model for the alu format decoder: drains or stalls decodes
// assumes the bench drives hold_off by non-blocking assignment on the edge
`timescale 1ns/1ps

module execute_sink (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stall request from the bench
    input wire logic hold_off,
    // handshake back to the decoder
    output logic exec_ready
);
    // registered, so ready only moves on an edge and a stall lags by one cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            exec_ready <= 1'b1;
        end else begin
            exec_ready <= !hold_off;
        end
    end
endmodule // execute_sink
